// ### pkg/dsbs_pkg.sv
package dsbs_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam logic [7:0] DSBS_BITRAM_BASE   = 8'h20;
    localparam logic [7:0] DSBS_BITRAM_LAST   = 8'h2f;
    localparam logic [7:0] DSBS_SFR_BASE      = 8'h80;
    localparam logic [7:0] DSBS_STACK_PTR_ADR = 8'h81;
    localparam logic [7:0] DSBS_STACK_PTR_RST = 8'h07;
    localparam logic [3:0] DSBS_BITSFR_NIB0   = 4'h0;
    localparam logic [3:0] DSBS_BITSFR_NIB8   = 4'h8;
    localparam int         DSBS_BITRAM_MSB    = 6;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DSBS_MODE_DIRECT   = 2'b00,
        DSBS_MODE_INDIRECT = 2'b01,
        DSBS_MODE_PUSH     = 2'b10,
        DSBS_MODE_POP      = 2'b11
    } dsbs_mode_e;

    // one access from the execution unit
    typedef struct packed {
        logic       valid;
        dsbs_mode_e mode;
        logic       is_bit;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wbit;
    } dsbs_req_s;

    // steered result toward memory and sfr space
    typedef struct packed {
        logic       ram_en;
        logic       ram_we;
        logic [7:0] ram_addr;
        logic [7:0] ram_wdata;
        logic       sfr_en;
        logic       sfr_we;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
        logic       bit_acc;
        logic [2:0] bit_pos;
        logic       bit_refused;
    } dsbs_route_s;

endpackage

// ### verilog/dsbs_decode.sv
// ----------------------------------------------------------------
// Summary of operation
// - bytes 0x20-0x2F also give 128 bits
// - bit address is 8*offset plus bit position
// - bit or byte chosen by operand type
// - stack pointer reaches all 256 bytes
// - push writes pointer+1 then increments
// - reset loads stack pointer with 0x07
// - stack depth limited only by 256 bytes
// - direct 0x80-0xFF goes to sfr space
// - bit sfr access only at nibble 0 or 8
// - stack pointer read/write at sfr 0x81
// - indirect above 0x7F reaches upper ram
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module dsbs_decode (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    // request from execution unit
    input  wire dsbs_pkg::dsbs_req_s  i_req,
    // read data returned by sfr space (other sfrs)
    input  wire logic [7:0]           i_sfr_rdata,
    // steering toward memory and sfrs
    output var dsbs_pkg::dsbs_route_s o_route,
    // stack pointer state and readback
    output logic [7:0]                o_stack_top_pointer,
    output logic [7:0]                o_sfr_rdata
);
    import dsbs_pkg::*;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic is_sfr_bitable(input logic [7:0] a);
        is_sfr_bitable = (a[3:0] == DSBS_BITSFR_NIB0) ||
                         (a[3:0] == DSBS_BITSFR_NIB8);
    endfunction

    logic [7:0]  stack_top_pointer_reg;
    logic [7:0]  stack_top_pointer_next;
    dsbs_route_s route_reg;
    dsbs_route_s route_next;

    wire logic       req_direct = i_req.valid &&
                                  (i_req.mode == DSBS_MODE_DIRECT);
    wire logic       req_indir  = i_req.valid &&
                                  (i_req.mode == DSBS_MODE_INDIRECT);
    wire logic       req_push   = i_req.valid &&
                                  (i_req.mode == DSBS_MODE_PUSH);
    wire logic       req_pop    = i_req.valid &&
                                  (i_req.mode == DSBS_MODE_POP);
    // a bit address below 0x80 lives in ram bytes 0x20-0x2f
    wire logic       bit_low    = ~i_req.addr[7];
    wire logic [7:0] bit_byte   = DSBS_BITRAM_BASE +
                                  {4'h0, i_req.addr[DSBS_BITRAM_MSB:3]};
    // high bit addresses name byte (addr & 0xf8) in sfr space
    wire logic [7:0] bit_sfr    = {i_req.addr[7:3], 3'b000};
    wire logic [7:0] byte_adr   = i_req.is_bit ?
                                  (bit_low ? bit_byte : bit_sfr) :
                                  i_req.addr;
    wire logic       to_sfr     = req_direct && byte_adr[7];
    wire logic       bit_bad    = to_sfr && i_req.is_bit &&
                                  !is_sfr_bitable(byte_adr);
    wire logic       hit_sp     = to_sfr && !i_req.is_bit &&
                                  (byte_adr == DSBS_STACK_PTR_ADR);
    // eight-bit sum drops the carry, so 0xff wraps to 0x00
    wire logic [7:0] sp_inc     = stack_top_pointer_reg + 8'h01;
    wire logic [7:0] sp_dec     = stack_top_pointer_reg - 8'h01;

    always_comb begin
        stack_top_pointer_next = stack_top_pointer_reg;
        if (req_push) begin
            stack_top_pointer_next = sp_inc;
        end else if (req_pop) begin
            stack_top_pointer_next = sp_dec;
        end else if (hit_sp && i_req.write) begin
            stack_top_pointer_next = i_req.wdata;
        end
    end

    always_comb begin
        route_next           = '0;
        route_next.bit_acc   = i_req.is_bit && (req_direct);
        route_next.bit_pos   = i_req.addr[2:0];
        route_next.ram_wdata = i_req.wdata;
        route_next.sfr_wdata = i_req.wdata;
        if (req_push) begin
            // full 8-bit pointer, no depth limit below 256 bytes
            route_next.ram_en   = 1'b1;
            route_next.ram_we   = 1'b1;
            route_next.ram_addr = sp_inc;
            route_next.bit_acc  = 1'b0;
        end else if (req_pop) begin
            route_next.ram_en   = 1'b1;
            route_next.ram_addr = stack_top_pointer_reg;
            route_next.bit_acc  = 1'b0;
        end else if (req_indir) begin
            // indirect never reaches sfrs, even above 0x7f
            route_next.ram_en   = 1'b1;
            route_next.ram_we   = i_req.write;
            route_next.ram_addr = i_req.addr;
            route_next.bit_acc  = 1'b0;
        end else if (to_sfr) begin
            route_next.bit_refused = bit_bad;
            route_next.sfr_en   = !bit_bad && !hit_sp;
            route_next.sfr_we   = !bit_bad && !hit_sp && i_req.write;
            route_next.sfr_addr = byte_adr;
        end else if (req_direct) begin
            route_next.ram_en   = 1'b1;
            route_next.ram_we   = i_req.write;
            route_next.ram_addr = byte_adr;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            stack_top_pointer_reg <= DSBS_STACK_PTR_RST;
        end else begin
            stack_top_pointer_reg <= stack_top_pointer_next;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            route_reg <= '0;
        end else begin
            route_reg <= route_next;
        end
    end

    logic [7:0] rdata_reg;
    logic       rd_sp_reg;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
            rd_sp_reg <= 1'b0;
        end else begin
            rdata_reg <= stack_top_pointer_reg;
            rd_sp_reg <= hit_sp && !i_req.write;
        end
    end

    assign o_route             = route_reg;
    assign o_stack_top_pointer = stack_top_pointer_reg;
    // sp read returns the value held when the read was taken
    assign o_sfr_rdata         = rd_sp_reg ? rdata_reg : i_sfr_rdata;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_push;
        i_req.valid && i_req.mode == DSBS_MODE_PUSH;
    endsequence

    sequence s_sp_read;
        hit_sp && !i_req.write;
    endsequence

    AST_PUSH_ADDR: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        s_push |=> (o_route.ram_we &&
                    o_route.ram_addr == o_stack_top_pointer))
        else $error("push did not write at new stack top");

    AST_PUSH_INC: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        s_push |=> (o_stack_top_pointer ==
                    8'($past(o_stack_top_pointer) + 8'h01)))
        else $error("push did not increment stack pointer by one");

    AST_PUSH_WRAP: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_push && o_stack_top_pointer == 8'hff) |=>
        (o_route.ram_addr == 8'h00 && o_stack_top_pointer == 8'h00))
        else $error("push at 0xff did not wrap to 0x00");

    AST_RST_SP: assert property (@(posedge i_mclk)
        i_rst |=> o_stack_top_pointer == 8'h07)
        else $error("stack pointer not 0x07 after reset");

    AST_BIT_MAP: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_direct && i_req.is_bit && !i_req.addr[7]) |=>
        (o_route.ram_en && o_route.bit_acc &&
         o_route.ram_addr == 8'h20 + {4'h0, $past(i_req.addr[6:3])} &&
         o_route.bit_pos == $past(i_req.addr[2:0])))
        else $error("bit address mapped to wrong ram byte");

    AST_BYTE_NOT_BIT: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_direct && !i_req.is_bit && !i_req.addr[7]) |=>
        (!o_route.bit_acc && o_route.ram_addr == $past(i_req.addr)))
        else $error("byte access treated as bit access");

    AST_SFR_STEER: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_direct && !i_req.is_bit && i_req.addr[7] &&
         i_req.addr != 8'h81) |=> (o_route.sfr_en && !o_route.ram_en))
        else $error("direct high access not steered to sfr space");

    AST_SFR_WRITE: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_direct && !i_req.is_bit && i_req.write && i_req.addr[7] &&
         i_req.addr != 8'h81) |=>
        (o_route.sfr_we && !o_route.ram_we &&
         o_route.sfr_addr == $past(i_req.addr)))
        else $error("direct high write not steered to sfr space");

    // a high bit address always names a byte whose low nibble is 0 or 8
    AST_SFR_BITABLE: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (req_direct && i_req.is_bit && i_req.addr[7]) |=>
        (!o_route.bit_refused && o_route.sfr_en && o_route.bit_acc &&
         o_route.sfr_addr == {$past(i_req.addr[7:3]), 3'b000}))
        else $error("sfr bit access permission wrong");

    AST_INDIRECT_RAM: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        req_indir |=> (o_route.ram_en && !o_route.sfr_en &&
                       o_route.ram_addr == $past(i_req.addr)))
        else $error("indirect access did not reach ram");

    AST_SP_WRITE: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        (hit_sp && i_req.write) |=>
        (o_stack_top_pointer == $past(i_req.wdata)))
        else $error("stack pointer write at 0x81 lost");

    AST_SP_READ: assert property (@(posedge i_mclk)
        disable iff (i_rst)
        s_sp_read |=> (o_sfr_rdata == $past(o_stack_top_pointer)))
        else $error("stack pointer read at 0x81 returned wrong value");

endmodule

`default_nettype wire

// ### test/dsbs_sfr_space_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// other sfrs: read data walks every cycle so a stale pass is caught
// ----------------------------------------------------------------
module dsbs_sfr_space_model (
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // read data toward the decoder
    output logic [7:0]      o_rdata
);
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= 8'h3c;
        end else begin
            o_rdata <= {o_rdata[6:0], ~o_rdata[7]};
        end
    end
endmodule
`default_nettype wire

// ### test/dsbs_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module dsbs_decode_bench;
    import dsbs_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rst  = 1'b1;
    dsbs_req_s   i_req  = '0;
    dsbs_route_s rt;
    logic [7:0]  sfr_rd, sp_o, rd_o, r;
    logic [56:0] exp_q[$], msk_q[$], e, k, act;
    logic        vld_d  = 1'b0;
    logic [7:0]  sp_m   = DSBS_STACK_PTR_RST;
    logic [31:0] rng    = 32'h0000000d;
    int          err_total = 0, comparisons = 0, cyc = 0;
    // assigned sfr addresses only: reserved ones have no defined effect
    logic [7:0]  tab [8] = '{8'h80, 8'h88, 8'h90, 8'h98, 8'ha8, 8'hb8,
                             8'hd0, 8'hf0};
    logic [7:0]  byt [8] = '{8'h81, 8'h89, 8'h99, 8'ha9, 8'hbb, 8'hd1,
                             8'hf1, 8'h93};
    always #10 i_mclk = ~i_mclk;
    dsbs_sfr_space_model u_sfr (.i_mclk(i_mclk), .i_rst(i_rst),
                                .o_rdata(sfr_rd));
    dsbs_decode dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req),
        .i_sfr_rdata(sfr_rd), .o_route(rt), .o_stack_top_pointer(sp_o),
        .o_sfr_rdata(rd_o));
    function automatic logic [7:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction
    // ----------------------------------------------------------------
    // driver: note the expectation, then present the request
    // ----------------------------------------------------------------
    task automatic send(input dsbs_mode_e m, input logic b, w,
                        input logic [7:0] a, d);
        logic [7:0]  rd, ra, sa;
        logic        re, se, bm, sm, we, swe;
        logic [56:0] ex, km;
        rd = 8'h00;
        ra = a;
        sa = a;
        re = 1'b0;
        se = 1'b0;
        sm = 1'b0;
        bm = b && m == DSBS_MODE_DIRECT;
        if (m == DSBS_MODE_PUSH) begin
            sp_m = sp_m + 8'h01;
            re = 1'b1;
            ra = sp_m;
        end else if (m == DSBS_MODE_POP) begin
            re = 1'b1;
            ra = sp_m;
            sp_m = sp_m - 8'h01;
        end else if (m == DSBS_MODE_INDIRECT || (!b && a < 8'h80)) begin
            re = 1'b1;
        end else if (bm && a < 8'h80) begin
            re = 1'b1;
            ra = 8'h20 + {4'h0, a[6:3]};
        end else if (a == DSBS_STACK_PTR_ADR && !b) begin
            sm = !w;
            rd = sp_m;
            if (w) sp_m = d;
        end else begin
            se = 1'b1;
            sa = b ? {a[7:3], 3'h0} : a;
        end
        // pop never writes; sfr and pointer accesses leave ram alone
        we = re && (m == DSBS_MODE_PUSH || (m != DSBS_MODE_POP && w));
        swe = se && w;
        ex = {rd, sp_m, re, we, ra, se, swe, sa, bm, a[2:0], 1'b0, d, d};
        km = {{8{sm}}, 8'hff, 2'b11, {8{re}}, 2'b11, {8{se}}, 1'b1,
              {3{bm}}, 1'b1, {8{we}}, {8{swe}}};
        @(negedge i_mclk);
        i_req = '{1'b1, m, b, w, a, d, 1'b0};
        exp_q.push_back(ex);
        msk_q.push_back(km);
    endtask
    always @(posedge i_mclk) begin
        vld_d <= i_req.valid && !i_rst;
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            tally_and_finish();
        end
    end
    always @(negedge i_mclk) begin
        if (vld_d) begin
            e = exp_q.pop_front();
            k = msk_q.pop_front();
            act = {rd_o, sp_o, rt.ram_en, rt.ram_we, rt.ram_addr, rt.sfr_en,
                   rt.sfr_we, rt.sfr_addr, rt.bit_acc, rt.bit_pos,
                   rt.bit_refused, rt.ram_wdata, rt.sfr_wdata};
            `CHK(act & k, e & k)
            if (k[56:49] == 8'h00) `CHK(rd_o, sfr_rd)
        end
    end
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(negedge i_mclk);
        i_rst = 1'b0;
        send(DSBS_MODE_PUSH, 1'b0, 1'b1, 8'h00, 8'h5a);
        send(DSBS_MODE_POP, 1'b0, 1'b0, 8'h00, 8'h00);
        send(DSBS_MODE_DIRECT, 1'b1, 1'b0, 8'h00, 8'h00);
        send(DSBS_MODE_DIRECT, 1'b1, 1'b1, 8'h07, 8'h00);
        send(DSBS_MODE_DIRECT, 1'b1, 1'b0, 8'h7f, 8'h00);
        send(DSBS_MODE_DIRECT, 1'b1, 1'b0, 8'h22, 8'h00);
        send(DSBS_MODE_DIRECT, 1'b0, 1'b0, 8'h22, 8'h00);
        repeat (24) begin
            r = xs();
            send(DSBS_MODE_DIRECT, 1'b1, r[7], {1'b0, r[6:0]}, 8'h00);
        end
        foreach (tab[i]) begin
            r = xs();
            send(DSBS_MODE_DIRECT, 1'b1, r[7], tab[i] | {5'h00, r[2:0]},
                 8'h00);
            send(DSBS_MODE_DIRECT, 1'b0, 1'b1, byt[i], r);
            send(DSBS_MODE_INDIRECT, 1'b0, r[0], tab[i], r);
        end
        send(DSBS_MODE_DIRECT, 1'b0, 1'b1, 8'h81, 8'hfe);
        send(DSBS_MODE_DIRECT, 1'b0, 1'b0, 8'h81, 8'h00);
        send(DSBS_MODE_PUSH, 1'b0, 1'b1, 8'h00, xs());
        send(DSBS_MODE_PUSH, 1'b0, 1'b1, 8'h00, xs());
        send(DSBS_MODE_POP, 1'b0, 1'b0, 8'h00, 8'h00);
        // mid-run reset must bring the pointer back from wherever it is
        @(negedge i_mclk);
        i_req.valid = 1'b0;
        i_rst = 1'b1;
        sp_m = DSBS_STACK_PTR_RST;
        @(negedge i_mclk);
        i_rst = 1'b0;
        send(DSBS_MODE_PUSH, 1'b0, 1'b1, 8'h00, 8'ha5);
        @(negedge i_mclk);
        i_req.valid = 1'b0;
        repeat (3) @(negedge i_mclk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
